// *** hw/ssc_pkg.sv ***
package ssc_pkg;
  // Switch bank bit positions (bit n of bank is switch n, index n-1)
  localparam int unsigned SSC_A_BAUD_LO   = 0;
  localparam int unsigned SSC_A_BAUD_HI   = 1;
  localparam int unsigned SSC_A_DELIM_LO  = 2;
  localparam int unsigned SSC_A_DELIM_HI  = 3;
  localparam int unsigned SSC_A_MEM_PROT  = 6;
  localparam int unsigned SSC_A_KNOB_LOCK = 7;
  localparam int unsigned SSC_B_BOOST     = 0;
  localparam int unsigned SSC_B_REDUCE    = 1;
  localparam int unsigned SSC_B_KNOB_REV  = 2;
  localparam int unsigned SSC_B_BL_REV    = 3;
  localparam int unsigned SSC_B_SEP_ORG   = 5;

  // Reset values of the captured setup
  localparam logic [3:0] SSC_HOLD_RST = 4'h5;
  localparam logic [3:0] SSC_CODE_RST = 4'h0;
  localparam logic [7:0] SSC_BANK_RST = 8'h00;

  // Settle count that ends WAIT; switches are captured 6 enabled cycles after reset release
  localparam logic [3:0] SSC_SETTLE_CYC = 4'h4;

  // Register offsets
  localparam logic [7:0] SSC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SSC_OFF_STAT   = 8'h04;
  localparam logic [7:0] SSC_OFF_CODES  = 8'h08;
  localparam logic [7:0] SSC_OFF_SPEED  = 8'h0c;
  localparam logic [7:0] SSC_OFF_PULSE  = 8'h10;
  localparam logic [7:0] SSC_OFF_FLAGS  = 8'h14;
  localparam int unsigned SSC_CTRL_REARM = 0;
  localparam logic [31:0] SSC_PULSE_LIMIT = 32'h0007a120;

  typedef enum logic [1:0] {
    SSC_DELIM_CRLF = 2'b00,
    SSC_DELIM_CR   = 2'b01,
    SSC_DELIM_LF   = 2'b10,
    SSC_DELIM_NONE = 2'b11
  } ssc_delim_e;

  typedef enum logic [1:0] {
    SSC_ST_WAIT = 2'b00,
    SSC_ST_LOAD = 2'b01,
    SSC_ST_RUN  = 2'b10
  } ssc_state_e;

  typedef struct packed {
    logic [7:0] div;
    logic [3:0] drive;
    logic [6:0] hold_pct;
    logic [15:0] baud;
    ssc_delim_e delim;
    logic       mem_wr_en;
    logic       knob_en;
    logic       knob_rev;
    logic       bl_rev;
    logic       sep_origin;
    logic [14:0] top_speed;
    logic [7:0] mult;
  } ssc_cfg_s;
endpackage : ssc_pkg

// *** hw/ssc_ratio_lut.sv ***
`timescale 1ns/100ps
module ssc_ratio_lut (
  input  wire logic [3:0] code,
  output logic      [7:0] ratio
);
  always_comb begin
    case (code)
      4'h0: ratio = 8'h01;
      4'h1: ratio = 8'h02;
      4'h2: ratio = 8'h04;
      4'h3: ratio = 8'h05;
      4'h4: ratio = 8'h08;
      4'h5: ratio = 8'h0a;
      4'h6: ratio = 8'h14;
      4'h7: ratio = 8'h28;
      4'h8: ratio = 8'h50;
      4'h9: ratio = 8'h10;
      4'ha: ratio = 8'h19;
      4'hb: ratio = 8'h32;
      4'hc: ratio = 8'h64;
      4'hd: ratio = 8'h7d;
      4'he: ratio = 8'hc8;
      4'hf: ratio = 8'hfa;
      default: ratio = 8'h01;
    endcase
  end
endmodule : ssc_ratio_lut

// *** hw/ssc_top.sv ***
`timescale 1ns/100ps
module ssc_top
  import ssc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              stop_loop_closed,
  input  wire logic [3:0]        step_division_code,
  input  wire logic [3:0]        drive_current_code,
  input  wire logic [3:0]        hold_current_code,
  input  wire logic [7:0]        setup_bank_a,
  input  wire logic [7:0]        setup_bank_b,
  input  wire logic [3:0]        top_speed_code,
  input  wire logic [3:0]        multiplier_switch,
  output ssc_pkg::ssc_cfg_s      cfg,
  output logic [31:0]            pulse_rate,
  output logic                   pulse_over_limit,
  output logic                   motion_halt,
  output logic                   cfg_valid
);
  import ssc_pkg::*;

  // Synchronisers for the loose switch and stop pins
  logic [35:0] sw_meta_q;
  logic [35:0] sw_sync_q;
  logic        stop_meta_q;
  logic        stop_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q   <= '0;
      sw_sync_q   <= '0;
      stop_meta_q <= 1'b0;
      stop_sync_q <= 1'b0;
    end else if (clk_en) begin
      sw_meta_q   <= {step_division_code, drive_current_code,
                      hold_current_code, setup_bank_a, setup_bank_b,
                      top_speed_code, multiplier_switch};
      sw_sync_q   <= sw_meta_q;
      stop_meta_q <= stop_loop_closed;
      stop_sync_q <= stop_meta_q;
    end
  end

  // Capture sequencer: waits for the synchroniser to fill
  ssc_state_e state_q;
  logic [3:0] settle_q;
  logic       rearm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= SSC_ST_WAIT;
      settle_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        SSC_ST_WAIT: begin
          settle_q <= settle_q + 4'h1;
          if (settle_q == SSC_SETTLE_CYC) begin
            state_q <= SSC_ST_LOAD;
          end
        end
        SSC_ST_LOAD: state_q <= SSC_ST_RUN;
        SSC_ST_RUN: begin
          // Software rearm models a fresh power cycle
          if (rearm_q) begin
            state_q  <= SSC_ST_WAIT;
            settle_q <= '0;
          end
        end
        default: state_q <= SSC_ST_WAIT;
      endcase
    end
  end

  logic [3:0] div_code_q;
  logic [3:0] drive_q;
  logic [3:0] hold_q;
  logic [7:0] bank_a_q;
  logic [7:0] bank_b_q;
  logic [3:0] speed_code_q;
  logic [3:0] mult_code_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_code_q   <= SSC_CODE_RST;
      drive_q      <= SSC_CODE_RST;
      hold_q       <= SSC_HOLD_RST;
      bank_a_q     <= SSC_BANK_RST;
      bank_b_q     <= SSC_BANK_RST;
      speed_code_q <= SSC_CODE_RST;
      mult_code_q  <= SSC_CODE_RST;
    end else if (clk_en && state_q == SSC_ST_LOAD) begin
      {div_code_q, drive_q, hold_q, bank_a_q, bank_b_q,
       speed_code_q, mult_code_q} <= sw_sync_q;
    end
  end

  // Two ratio tables share one lookup module
  logic [7:0] div_val;
  logic [7:0] mult_val;
  ssc_ratio_lut u_div_lut (
    .code  (div_code_q),
    .ratio (div_val)
  );
  ssc_ratio_lut u_mult_lut (
    .code  (mult_code_q),
    .ratio (mult_val)
  );

  // Hold current percent, a table because steps are uneven
  logic [6:0] hold_pct;
  always_comb begin
    case (hold_q)
      4'h0: hold_pct = 7'd25;
      4'h1: hold_pct = 7'd30;
      4'h2: hold_pct = 7'd35;
      4'h3: hold_pct = 7'd41;
      4'h4: hold_pct = 7'd45;
      4'h5: hold_pct = 7'd50;
      4'h6: hold_pct = 7'd55;
      4'h7: hold_pct = 7'd59;
      4'h8: hold_pct = 7'd63;
      4'h9: hold_pct = 7'd67;
      4'ha: hold_pct = 7'd71;
      4'hb: hold_pct = 7'd75;
      4'hc: hold_pct = 7'd79;
      4'hd: hold_pct = 7'd83;
      4'he: hold_pct = 7'd87;
      4'hf: hold_pct = 7'd91;
      default: hold_pct = 7'd50;
    endcase
  end

  // Base and boosted top speed columns
  logic [14:0] spd_base;
  logic [14:0] spd_boost;
  always_comb begin
    case (speed_code_q)
      4'h0: begin spd_base = 15'd500;   spd_boost = 15'd750;   end
      4'h1: begin spd_base = 15'd1000;  spd_boost = 15'd1500;  end
      4'h2: begin spd_base = 15'd2000;  spd_boost = 15'd2500;  end
      4'h3: begin spd_base = 15'd3000;  spd_boost = 15'd3500;  end
      4'h4: begin spd_base = 15'd4000;  spd_boost = 15'd4500;  end
      4'h5: begin spd_base = 15'd5000;  spd_boost = 15'd5500;  end
      4'h6: begin spd_base = 15'd6000;  spd_boost = 15'd6500;  end
      4'h7: begin spd_base = 15'd7000;  spd_boost = 15'd7500;  end
      4'h8: begin spd_base = 15'd8000;  spd_boost = 15'd8500;  end
      4'h9: begin spd_base = 15'd9000;  spd_boost = 15'd9500;  end
      4'ha: begin spd_base = 15'd10000; spd_boost = 15'd10500; end
      4'hb: begin spd_base = 15'd11000; spd_boost = 15'd12000; end
      4'hc: begin spd_base = 15'd13000; spd_boost = 15'd14000; end
      4'hd: begin spd_base = 15'd15000; spd_boost = 15'd16000; end
      4'he: begin spd_base = 15'd17000; spd_boost = 15'd18500; end
      4'hf: begin spd_base = 15'd20000; spd_boost = 15'd22000; end
      default: begin spd_base = 15'd500; spd_boost = 15'd750; end
    endcase
  end

  // Every table entry divides by ten exactly
  logic [14:0] spd_col;
  logic [14:0] top_speed;
  always_comb begin
    spd_col = bank_b_q[SSC_B_BOOST] ? spd_boost : spd_base;
    top_speed = bank_b_q[SSC_B_REDUCE] ? 15'(spd_col / 15'd10)
                                       : spd_col;
  end

  logic [15:0] baud;
  always_comb begin
    case ({bank_a_q[SSC_A_BAUD_LO], bank_a_q[SSC_A_BAUD_HI]})
      2'b00:   baud = 16'd4800;
      2'b01:   baud = 16'd9600;
      2'b10:   baud = 16'd19200;
      2'b11:   baud = 16'd38400;
      default: baud = 16'd9600;
    endcase
  end

  ssc_cfg_s cfg_d;
  always_comb begin
    cfg_d.div        = div_val;
    cfg_d.drive      = drive_q;
    cfg_d.hold_pct   = hold_pct;
    cfg_d.baud       = baud;
    cfg_d.delim      = ssc_delim_e'({bank_a_q[SSC_A_DELIM_LO],
                                     bank_a_q[SSC_A_DELIM_HI]});
    cfg_d.mem_wr_en  = !bank_a_q[SSC_A_MEM_PROT];
    cfg_d.knob_en    = !bank_a_q[SSC_A_KNOB_LOCK];
    cfg_d.knob_rev   = bank_b_q[SSC_B_KNOB_REV];
    cfg_d.bl_rev     = bank_b_q[SSC_B_BL_REV];
    cfg_d.sep_origin = bank_b_q[SSC_B_SEP_ORG];
    cfg_d.top_speed  = top_speed;
    cfg_d.mult       = mult_val;
  end
  // Bank bits 5,6 of A and 5,7,8 of B are never decoded; only the FLAGS register reads them

  logic [31:0] pulse_d;
  assign pulse_d = 32'(top_speed) * 32'(mult_val);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg              <= '0;
      pulse_rate       <= '0;
      pulse_over_limit <= 1'b0;
      cfg_valid        <= 1'b0;
    end else if (clk_en) begin
      cfg              <= cfg_d;
      pulse_rate       <= pulse_d;
      pulse_over_limit <= pulse_d > SSC_PULSE_LIMIT;
      cfg_valid        <= state_q == SSC_ST_RUN;
    end
  end

  // Halt path is combinational after the synchroniser
  assign motion_halt = !stop_sync_q;

  // APB slave, zero wait states
  logic apb_wr;
  logic addr_ok;
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  always_comb begin
    case (paddr)
      SSC_OFF_CTRL, SSC_OFF_STAT, SSC_OFF_CODES,
      SSC_OFF_SPEED, SSC_OFF_PULSE, SSC_OFF_FLAGS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rearm_q <= 1'b0;
    end else if (clk_en) begin
      rearm_q <= apb_wr && paddr == SSC_OFF_CTRL &&
                 pwdata[SSC_CTRL_REARM];
    end
  end

  always_comb begin
    case (paddr)
      SSC_OFF_STAT:  prdata = {28'h0, pulse_over_limit, motion_halt,
                              cfg_valid, stop_sync_q};
      SSC_OFF_CODES: prdata = {4'h0, div_code_q, drive_q, hold_q,
                              speed_code_q, mult_code_q, 8'h00};
      SSC_OFF_SPEED: prdata = {17'h0, cfg.top_speed};
      SSC_OFF_PULSE: prdata = pulse_rate;
      SSC_OFF_FLAGS: prdata = {16'h0, bank_a_q, bank_b_q};
      default:       prdata = 32'h0;
    endcase
  end

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
      clk_en && $past(clk_en) && !$past(stop_loop_closed) |=> motion_halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt does not follow stop loop");
  property p_load;
    @(posedge pclk) disable iff (!presetn)
      state_q == SSC_ST_RUN && $past(state_q) == SSC_ST_RUN
      |-> $stable({bank_a_q, bank_b_q, speed_code_q, mult_code_q});
  endproperty
  a_load: assert property (p_load)
    else $error("switch capture changed while running");
  property p_boost;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !bank_b_q[SSC_B_REDUCE] && bank_b_q[SSC_B_BOOST]
      && speed_code_q == 4'hf |=> cfg.top_speed == 15'd22000;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost column wrong");
  property p_reduce;
    @(posedge pclk) disable iff (!presetn)
      clk_en && bank_b_q[SSC_B_REDUCE] && !bank_b_q[SSC_B_BOOST]
      && speed_code_q == 4'hc |=> cfg.top_speed == 15'd1300;
  endproperty
  a_reduce: assert property (p_reduce)
    else $error("reduce column wrong");
  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
      clk_en |=> pulse_rate == 32'($past(top_speed)) * 32'($past(mult_val));
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse rate mismatch");
  property p_memp;
    @(posedge pclk) disable iff (!presetn)
      clk_en && bank_a_q[SSC_A_MEM_PROT] |=> !cfg.mem_wr_en;
  endproperty
  a_memp: assert property (p_memp)
    else $error("memory write not blocked");
  property p_knob;
    @(posedge pclk) disable iff (!presetn)
      clk_en && bank_a_q[SSC_A_KNOB_LOCK] |=> !cfg.knob_en;
  endproperty
  a_knob: assert property (p_knob)
    else $error("knob not locked");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      clk_en && hold_q == 4'h5 |=> cfg.hold_pct == 7'd50;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold percent wrong");
  property p_baud;
    @(posedge pclk) disable iff (!presetn)
      clk_en && bank_a_q[1:0] == 2'b11 |=> cfg.baud == 16'd38400;
  endproperty
  a_baud: assert property (p_baud)
    else $error("baud wrong");
endmodule : ssc_top

// *** dv/ssc_stage_model.sv ***
`timescale 1ns/100ps
module ssc_stage_model
  import ssc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cfg_valid,
  input  wire logic        motion_halt,
  input  wire logic        pulse_over_limit,
  output logic             moving
);
  // Driver refuses to step past its pulse limit, like the real one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving <= 1'b0;
    end else begin
      moving <= cfg_valid & ~motion_halt & ~pulse_over_limit;
    end
  end
endmodule : ssc_stage_model

// *** dv/ssc_tb.sv ***
`timescale 1ns/100ps
module testbench;
  import ssc_pkg::*;
  typedef struct {
    logic [3:0] code;
    logic [7:0] a;
    logic [7:0] b;
    int         spd;
  } ssc_row_s;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, bank_a, bank_b;
  logic [31:0] pwdata, prdata, pulse_rate, rd;
  logic        stop_loop_closed, pulse_over_limit, motion_halt, cfg_valid;
  logic        moving, err;
  logic [3:0]  code;
  ssc_cfg_s    cfg, held;
  int          failures, checks_done;
  int divtab[16] = '{1,2,4,5,8,10,20,40,80,16,25,50,100,125,200,250};
  int holdtab[16] = '{25,30,35,41,45,50,55,59,63,67,71,75,79,83,87,91};
  // Reserved switches set in several rows; they must not matter
  ssc_row_s rows[8] = '{
    '{4'h0, 8'h00, 8'h00, 500},  '{4'h3, 8'h31, 8'hd1, 3500},
    '{4'h7, 8'h45, 8'h06, 700},  '{4'h8, 8'h8a, 8'h0b, 850},
    '{4'hb, 8'hc3, 8'h21, 12000}, '{4'he, 8'hcf, 8'h2e, 1700},
    '{4'hf, 8'h00, 8'h01, 22000}, '{4'hc, 8'ha6, 8'h12, 1300}};
  ssc_row_s    late = '{4'h1, 8'hff, 8'h00, 1000};

  ssc_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_loop_closed(stop_loop_closed), .step_division_code(code),
    .drive_current_code(code), .hold_current_code(code),
    .setup_bank_a(bank_a), .setup_bank_b(bank_b), .top_speed_code(code),
    .multiplier_switch(code), .cfg(cfg), .pulse_rate(pulse_rate),
    .pulse_over_limit(pulse_over_limit), .motion_halt(motion_halt),
    .cfg_valid(cfg_valid));
  ssc_stage_model i_stage (.pclk(pclk), .presetn(presetn),
    .cfg_valid(cfg_valid), .motion_halt(motion_halt),
    .pulse_over_limit(pulse_over_limit), .moving(moving));

  always #50 pclk = ~pclk;

  function automatic ssc_cfg_s expect_cfg(ssc_row_s r);
    ssc_cfg_s e;
    e.div        = 8'(divtab[r.code]);
    e.drive      = r.code;
    e.hold_pct   = 7'(holdtab[r.code]);
    e.baud       = 16'(4800 << {r.a[0], r.a[1]});
    e.delim      = ssc_delim_e'({r.a[2], r.a[3]});
    e.mem_wr_en  = ~r.a[6];
    e.knob_en    = ~r.a[7];
    e.knob_rev   = r.b[2];
    e.bl_rev     = r.b[3];
    e.sep_origin = r.b[5];
    e.top_speed  = 15'(r.spd);
    e.mult       = 8'(divtab[r.code]);
    return e;
  endfunction : expect_cfg

  task automatic chk(input logic [79:0] got, input logic [79:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      failures++;
      $display("Error at %0t: bus answer timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic power_up(input ssc_row_s r);
    int n;
    n = 0;
    code <= r.code; bank_a <= r.a; bank_b <= r.b; presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    while (cfg_valid !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (cfg_valid !== 1'b1) begin
      failures++;
      $display("Error at %0t: capture never completed", $time);
    end
    @(posedge pclk);
    #1;
  endtask : power_up

  task automatic give_verdict;
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    #2000000;
    failures++;
    give_verdict();
  end

  initial begin
    longint p;
    pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; stop_loop_closed = 1; code = 0; bank_a = 0;
    bank_b = 0; failures = 0; checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SSC_OFF_CODES, 32'h0);
    chk(rd[19:16], 4'h5, "default hold code");
    chk(cfg_valid, 1'b0, "valid before capture");
    foreach (rows[i]) begin
      power_up(rows[i]);
      p = longint'(rows[i].spd) * divtab[rows[i].code];
      chk(cfg, expect_cfg(rows[i]), "decoded cfg");
      chk(pulse_rate, p[31:0], "pulse rate");
      chk(pulse_over_limit, p > 500000, "over limit");
      chk(moving, p <= 500000, "stage moving");
      @(posedge pclk);
      apb(1'b0, SSC_OFF_CODES, 32'h0);
      chk(rd, {4'h0, {5{rows[i].code}}, 8'h00}, "codes reg");
      apb(1'b0, SSC_OFF_PULSE, 32'h0);
      chk(rd, p[31:0], "pulse reg");
    end
    held = cfg;
    code <= late.code; bank_a <= late.a; bank_b <= late.b;
    repeat (20) @(posedge pclk);
    chk(cfg, held, "switches ignored when live");
    apb(1'b1, SSC_OFF_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    chk(cfg, expect_cfg(late), "rearm capture");
    stop_loop_closed <= 1'b0;
    @(posedge pclk);
    #1 chk(motion_halt, 1'b0, "halt one edge");
    @(posedge pclk);
    #1 chk(motion_halt, 1'b1, "halt two edges");
    @(posedge pclk);
    apb(1'b0, SSC_OFF_STAT, 32'h0);
    chk(rd[2:0], 3'b110, "status halted");
    chk(moving, 1'b0, "stage stopped");
    stop_loop_closed <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(motion_halt, 1'b0, "loop closed again");
    @(posedge pclk);
    clk_en <= 1'b0; stop_loop_closed <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 chk(motion_halt, 1'b0, "frozen when disabled");
    @(posedge pclk);
    clk_en <= 1'b1; stop_loop_closed <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1, "unmapped address");
    @(posedge pclk);
    give_verdict();
  end
endmodule : testbench
